// ---- shared/tmr2_pkg.sv ----
// Package: register map, field positions, reset values and modes for timer 2
package tmr2_pkg;
	// Byte addresses on the APB
	localparam logic [7:0] ADDR_CTRL = 8'hC8;
	localparam logic [7:0] ADDR_MODE = 8'hC9;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
	// Control register fields
	localparam int CTRL_OVF = 7;
	localparam int CTRL_EXT = 6;
	localparam int CTRL_RXB = 5;
	localparam int CTRL_TXB = 4;
	localparam int CTRL_EXEN = 3;
	localparam int CTRL_RUN = 2;
	localparam int CTRL_CSEL = 1;
	localparam int CTRL_CAPT = 0;
	// Mode register fields
	localparam int MODE_CLKOUT = 1;
	localparam int MODE_UPDOWN = 0;
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	// Timer tick divider: internal clock counts at F/12
	localparam int TICK_DIV = 12;
	localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

	// Operating mode decoded from control bits
	typedef enum logic [2:0] {
		TM_RELOAD = 3'b001,
		TM_CAPTURE = 3'b010,
		TM_BAUD = 3'b100
	} tmr2_mode_t;

	// Complete block state
	typedef struct packed {
		logic [7:0] ctrl;
		logic [1:0] mode;
		logic [15:0] reload;
		logic [15:0] count;
		logic [3:0] div;
		logic half;
		logic [2:0] pin_sync;
		logic pin_prev;
		logic [2:0] dir_sync;
		logic clk_out;
		logic [31:0] prdata;
	} tmr2_state_t;
endpackage

// ---- rtl/tmr2_top.sv ----
// Timer 2: 16-bit up/down auto-reload timer with clock output, APB slave
//
// Operation
// - Count is two cascaded eight-bit halves
// - Select internal tick or falling pin edges
// - Advance only while run is set
// - Capture, reload and baud modes from bits
// - Updown bit turns reload into up/down
// - Direction pin high counts up, low down
// - Up overflow at FFFF sets overflow flag, except in baud or clock-out mode
// - Up overflow loads reload value
// - Down underflow when count equals reload
// - Underflow sets flag and loads FFFF
// - External flag toggles, no interrupt request
// - Clock out has fifty percent duty
// - Clock out counts at half oscillator
// - Output frequency F over four times span
// - Clock out overflow raises no interrupt
// - Generated clock drives the count pin
// - Baud and clock out share reload
// - Control register resets to zero
// - Mode register holds clkout and updown
`timescale 1ns/1ps
module tmr2_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Pins
	input wire logic i_count_clock_pin,
	input wire logic i_direction_pin,
	output logic o_count_clock_pin,
	output logic o_count_clock_pin_oe_n,
	// Interrupt request toward the system controller
	output logic o_irq
);
	tmr2_pkg::tmr2_state_t s_q;
	tmr2_pkg::tmr2_state_t s_d;
	logic wr;
	logic rd;
	logic mapped;
	logic tick;
	logic pin_fall;
	logic inc_en;
	logic clkout;
	logic updown;
	logic dir_up;
	logic at_top;
	logic at_reload;
	logic wrap;
	logic irq_ev;
	tmr2_pkg::tmr2_mode_t op_mode;

	// Register address decode
	function automatic logic is_mapped(input logic [7:0] a);
		return a == tmr2_pkg::ADDR_CTRL || a == tmr2_pkg::ADDR_MODE ||
			a == tmr2_pkg::ADDR_RELOAD_LOW || a == tmr2_pkg::ADDR_RELOAD_HIGH ||
			a == tmr2_pkg::ADDR_COUNT_LOW || a == tmr2_pkg::ADDR_COUNT_HIGH;
	endfunction

	// APB strobes; zero wait states
	assign wr = i_psel && i_penable && i_pwrite;
	assign rd = i_psel && !i_penable && !i_pwrite;
	assign mapped = is_mapped(i_paddr);
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mapped;
	assign o_prdata = s_q.prdata;

	// Mode decode: baud bits override capture select
	always_comb begin
		if (s_q.ctrl[tmr2_pkg::CTRL_RXB] || s_q.ctrl[tmr2_pkg::CTRL_TXB]) begin
			op_mode = tmr2_pkg::TM_BAUD;
		end else if (s_q.ctrl[tmr2_pkg::CTRL_CAPT]) begin
			op_mode = tmr2_pkg::TM_CAPTURE;
		end else begin
			op_mode = tmr2_pkg::TM_RELOAD;
		end
	end

	// Count source and direction
	assign clkout = s_q.mode[tmr2_pkg::MODE_CLKOUT];
	assign updown = s_q.mode[tmr2_pkg::MODE_UPDOWN] &&
		op_mode == tmr2_pkg::TM_RELOAD && !clkout;
	assign tick = s_q.div == tmr2_pkg::TICK_LAST;
	// A fall counts once stages two and three agree low
	assign pin_fall = s_q.pin_prev && !s_q.pin_sync[2] && !s_q.pin_sync[1];
	// Clock out always runs from the half-rate tick, ignoring the select
	always_comb begin
		if (!s_q.ctrl[tmr2_pkg::CTRL_RUN]) begin
			inc_en = 1'b0;
		end else if (clkout) begin
			inc_en = s_q.half;
		end else if (s_q.ctrl[tmr2_pkg::CTRL_CSEL]) begin
			inc_en = pin_fall;
		end else begin
			inc_en = tick;
		end
	end
	// Direction pin read from the third stage alone, with no agreement check
	assign dir_up = !updown || s_q.dir_sync[2];
	assign at_top = s_q.count == tmr2_pkg::COUNT_MAX;
	assign at_reload = s_q.count == s_q.reload;
	assign wrap = inc_en && (dir_up ? at_top : at_reload);
	// Clock-out and baud overflows request no interrupt
	assign irq_ev = wrap && !clkout && op_mode != tmr2_pkg::TM_BAUD;

	// Next-state logic for the whole block
	always_comb begin
		s_d = s_q;
		s_d.pin_sync = {s_q.pin_sync[1:0], i_count_clock_pin};
		s_d.dir_sync = {s_q.dir_sync[1:0], i_direction_pin};
		if (s_q.pin_sync[2] == s_q.pin_sync[1]) begin
			s_d.pin_prev = s_q.pin_sync[2];
		end
		s_d.div = tick ? 4'h0 : s_q.div + 4'h1;
		s_d.half = !s_q.half;
		// Counter: low byte carries into high through the 16-bit add
		if (inc_en) begin
			if (wrap) begin
				if (dir_up) begin
					s_d.count = s_q.reload;
				end else begin
					s_d.count = tmr2_pkg::COUNT_MAX;
				end
				// Toggle each wrap gives a 50% square wave at F/4/span
				if (clkout) begin
					s_d.clk_out = !s_q.clk_out;
				end
			end else if (dir_up) begin
				s_d.count = s_q.count + 16'h0001;
			end else begin
				s_d.count = s_q.count - 16'h0001;
			end
		end
		// Software writes; flags can only be cleared
		if (wr && mapped) begin
			unique case (i_paddr)
				tmr2_pkg::ADDR_CTRL: begin
					s_d.ctrl[5:0] = i_pwdata[5:0];
					if (!i_pwdata[tmr2_pkg::CTRL_OVF]) begin
						s_d.ctrl[tmr2_pkg::CTRL_OVF] = 1'b0;
					end
					if (!i_pwdata[tmr2_pkg::CTRL_EXT]) begin
						s_d.ctrl[tmr2_pkg::CTRL_EXT] = 1'b0;
					end
				end
				tmr2_pkg::ADDR_MODE: s_d.mode = i_pwdata[1:0];
				tmr2_pkg::ADDR_RELOAD_LOW: s_d.reload[7:0] = i_pwdata[7:0];
				tmr2_pkg::ADDR_RELOAD_HIGH: s_d.reload[15:8] = i_pwdata[7:0];
				tmr2_pkg::ADDR_COUNT_LOW: s_d.count[7:0] = i_pwdata[7:0];
				tmr2_pkg::ADDR_COUNT_HIGH: s_d.count[15:8] = i_pwdata[7:0];
				default: ;
			endcase
		end
		// Hardware set wins over a same-cycle clear
		if (irq_ev) begin
			s_d.ctrl[tmr2_pkg::CTRL_OVF] = 1'b1;
		end
		if (wrap && updown) begin
			s_d.ctrl[tmr2_pkg::CTRL_EXT] = !s_q.ctrl[tmr2_pkg::CTRL_EXT];
		end
		// Read data latched in setup phase
		if (rd) begin
			s_d.prdata = 32'h0000_0000;
			unique case (i_paddr)
				tmr2_pkg::ADDR_CTRL: s_d.prdata[7:0] = s_q.ctrl;
				tmr2_pkg::ADDR_MODE: s_d.prdata[1:0] = s_q.mode;
				tmr2_pkg::ADDR_RELOAD_LOW: s_d.prdata[7:0] = s_q.reload[7:0];
				tmr2_pkg::ADDR_RELOAD_HIGH: s_d.prdata[7:0] = s_q.reload[15:8];
				tmr2_pkg::ADDR_COUNT_LOW: s_d.prdata[7:0] = s_q.count[7:0];
				tmr2_pkg::ADDR_COUNT_HIGH: s_d.prdata[7:0] = s_q.count[15:8];
				default: ;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q <= '0;
			s_q.ctrl <= tmr2_pkg::CTRL_RESET;
			s_q.mode <= tmr2_pkg::MODE_RESET;
			s_q.count <= tmr2_pkg::COUNT_RESET;
			s_q.pin_sync <= 3'h7;
			s_q.pin_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Pin drive: enable active low while clock out is on
	assign o_count_clock_pin = s_q.clk_out;
	assign o_count_clock_pin_oe_n = !clkout;
	assign o_irq = s_q.ctrl[tmr2_pkg::CTRL_OVF];

	// Assertions
	property p_hold;
		@(posedge i_clk) disable iff (!i_arst_n)
		!s_q.ctrl[tmr2_pkg::CTRL_RUN] && !wr |=> $stable(s_q.count);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved while stopped");
	property p_up_reload;
		@(posedge i_clk) disable iff (!i_arst_n)
		wrap && dir_up && !wr |=> s_q.count == $past(s_q.reload);
	endproperty
	a_up_reload: assert property (p_up_reload) else $error("no reload");
	property p_down_max;
		@(posedge i_clk) disable iff (!i_arst_n)
		wrap && !dir_up && !wr |=> s_q.count == 16'hFFFF;
	endproperty
	a_down_max: assert property (p_down_max) else $error("no FFFF load");
	property p_flag;
		@(posedge i_clk) disable iff (!i_arst_n)
		irq_ev |=> o_irq;
	endproperty
	a_flag: assert property (p_flag) else $error("flag not set");
	property p_ext;
		@(posedge i_clk) disable iff (!i_arst_n)
		wrap && updown |=> s_q.ctrl[6] != $past(s_q.ctrl[6]);
	endproperty
	a_ext: assert property (p_ext) else $error("ext flag no toggle");
	property p_noirq_clk;
		@(posedge i_clk) disable iff (!i_arst_n)
		clkout && !o_irq |=> !o_irq;
	endproperty
	a_noirq_clk: assert property (p_noirq_clk) else $error("clkout irq");
	property p_oe;
		@(posedge i_clk) disable iff (!i_arst_n)
		o_count_clock_pin_oe_n == !s_q.mode[1];
	endproperty
	a_oe: assert property (p_oe) else $error("pin drive wrong");
	property p_half;
		@(posedge i_clk) disable iff (!i_arst_n)
		clkout && s_q.ctrl[tmr2_pkg::CTRL_RUN] |-> inc_en == s_q.half;
	endproperty
	a_half: assert property (p_half) else $error("not half rate");
	// Half-rate enable alternates every cycle
	property p_half_toggle;
		@(posedge i_clk) disable iff (!i_arst_n)
		1'b1 |=> s_q.half != $past(s_q.half);
	endproperty
	a_half_toggle: assert property (p_half_toggle) else $error("half stuck");
	// A single pin fall must not count twice
	property p_fall_once;
		@(posedge i_clk) disable iff (!i_arst_n)
		pin_fall |=> !pin_fall;
	endproperty
	a_fall_once: assert property (p_fall_once) else $error("double fall");
	// Internal tick is a one-cycle pulse
	property p_tick_gap;
		@(posedge i_clk) disable iff (!i_arst_n)
		tick |=> !tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick too long");
	// Divider never leaves its range
	property p_div_range;
		@(posedge i_clk) disable iff (!i_arst_n)
		s_q.div <= tmr2_pkg::TICK_LAST;
	endproperty
	a_div_range: assert property (p_div_range) else $error("divider range");
	// No advance without run
	property p_run_inc;
		@(posedge i_clk) disable iff (!i_arst_n)
		!s_q.ctrl[tmr2_pkg::CTRL_RUN] |-> !inc_en;
	endproperty
	a_run_inc: assert property (p_run_inc) else $error("inc while stopped");
	// Counter mode follows pin falls only
	property p_csel_pin;
		@(posedge i_clk) disable iff (!i_arst_n)
		s_q.ctrl[tmr2_pkg::CTRL_RUN] && !clkout &&
		s_q.ctrl[tmr2_pkg::CTRL_CSEL] |-> inc_en == pin_fall;
	endproperty
	a_csel_pin: assert property (p_csel_pin) else $error("pin select");
	// Timer mode follows the internal tick only
	property p_timer_tick;
		@(posedge i_clk) disable iff (!i_arst_n)
		s_q.ctrl[tmr2_pkg::CTRL_RUN] && !clkout &&
		!s_q.ctrl[tmr2_pkg::CTRL_CSEL] |-> inc_en == tick;
	endproperty
	a_timer_tick: assert property (p_timer_tick) else $error("tick select");
	// Up step carries from low into high byte
	property p_up_step;
		@(posedge i_clk) disable iff (!i_arst_n)
		inc_en && !wrap && dir_up && !wr |=>
		s_q.count == $past(s_q.count) + 16'h0001;
	endproperty
	a_up_step: assert property (p_up_step) else $error("bad up step");
	// Down step borrows across both bytes
	property p_dn_step;
		@(posedge i_clk) disable iff (!i_arst_n)
		inc_en && !wrap && !dir_up && !wr |=>
		s_q.count == $past(s_q.count) - 16'h0001;
	endproperty
	a_dn_step: assert property (p_dn_step) else $error("bad down step");
	// Up wrap only from the top value
	property p_up_top;
		@(posedge i_clk) disable iff (!i_arst_n)
		wrap && dir_up |-> at_top;
	endproperty
	a_up_top: assert property (p_up_top) else $error("early overflow");
	// Down wrap only at the reload value
	property p_dn_reload;
		@(posedge i_clk) disable iff (!i_arst_n)
		wrap && !dir_up |-> at_reload;
	endproperty
	a_dn_reload: assert property (p_dn_reload) else $error("early underflow");
	// Overflow flag sticks until software clears it
	property p_ovf_sticky;
		@(posedge i_clk) disable iff (!i_arst_n)
		s_q.ctrl[tmr2_pkg::CTRL_OVF] && !wr |=> s_q.ctrl[tmr2_pkg::CTRL_OVF];
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("flag lost");
	// External flag moves only on a wrap or a write
	property p_ext_quiet;
		@(posedge i_clk) disable iff (!i_arst_n)
		!(wrap && updown) && !wr |=> $stable(s_q.ctrl[tmr2_pkg::CTRL_EXT]);
	endproperty
	a_ext_quiet: assert property (p_ext_quiet) else $error("ext flag moved");
	// Low direction pin gives down count in up/down mode
	property p_dir_down;
		@(posedge i_clk) disable iff (!i_arst_n)
		updown && !s_q.dir_sync[2] |-> !dir_up;
	endproperty
	a_dir_down: assert property (p_dir_down) else $error("not counting down");
	// Without the updown bit the timer only counts up
	property p_updown_off;
		@(posedge i_clk) disable iff (!i_arst_n)
		!s_q.mode[tmr2_pkg::MODE_UPDOWN] |-> dir_up;
	endproperty
	a_updown_off: assert property (p_updown_off) else $error("down w/o updown");
	// Clock out flips on every wrap
	property p_clk_toggle;
		@(posedge i_clk) disable iff (!i_arst_n)
		wrap && clkout |=> o_count_clock_pin != $past(o_count_clock_pin);
	endproperty
	a_clk_toggle: assert property (p_clk_toggle) else $error("no clock flip");
	// Clock out holds between wraps, keeping the duty even
	property p_clk_steady;
		@(posedge i_clk) disable iff (!i_arst_n)
		!(wrap && clkout) |=> $stable(o_count_clock_pin);
	endproperty
	a_clk_steady: assert property (p_clk_steady) else $error("clock glitch");
	// Clock-out wraps raise no flag
	property p_clkout_noflag;
		@(posedge i_clk) disable iff (!i_arst_n)
		clkout |-> !irq_ev;
	endproperty
	a_clkout_noflag: assert property (p_clkout_noflag) else $error("clkout flag");
	// Baud mode wraps raise no flag
	property p_baud_noflag;
		@(posedge i_clk) disable iff (!i_arst_n)
		op_mode == tmr2_pkg::TM_BAUD |-> !irq_ev;
	endproperty
	a_baud_noflag: assert property (p_baud_noflag) else $error("baud flag");
	// Refused writes leave the registers alone
	property p_wr_refused;
		@(posedge i_clk) disable iff (!i_arst_n)
		wr && !mapped |=> $stable(s_q.mode) && $stable(s_q.reload);
	endproperty
	a_wr_refused: assert property (p_wr_refused) else $error("bad write hit");
	// Upper read bits are always zero
	property p_rd_upper;
		@(posedge i_clk) disable iff (!i_arst_n)
		o_prdata[31:8] == 24'h000000;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
	// Zero wait states on every transfer
	property p_pready;
		@(posedge i_clk) disable iff (!i_arst_n)
		o_pready;
	endproperty
	a_pready: assert property (p_pready) else $error("wait state");
	// Main scenarios reached
	c_ext_fall: cover property (@(posedge i_clk) pin_fall && inc_en);
	c_updown_wrap: cover property (@(posedge i_clk) wrap && updown);
	c_wrap_up: cover property (@(posedge i_clk) wrap && dir_up);
	c_wrap_dn: cover property (@(posedge i_clk) wrap && !dir_up);
	c_clkout: cover property (@(posedge i_clk) clkout && wrap);
endmodule

// ---- verification/tmr2_far_model.sv ----
// Far side of timer 2: event source, direction pin and clock-out load
`timescale 1ns/1ps
module tmr2_far_model (
	// Clock
	input wire logic i_clk,
	// From the block
	input wire logic i_pin_out,
	input wire logic i_pin_oe_n,
	// To the block
	output logic o_pin,
	output logic o_dir
);
	logic drv = 1'b1;
	// Shared pin: pull-up idle, the block wins while it drives
	assign o_pin = i_pin_oe_n ? drv : i_pin_out;
	initial o_dir = 1'b1;
	// Direction level changes right after an edge
	task automatic set_dir(input logic v);
		@(posedge i_clk);
		o_dir <= v;
	endtask
	// Falling edges; hold sets fast or slow events for the synchroniser
	task automatic pulse(input int n, input int hold);
		repeat (n) begin
			@(posedge i_clk);
			drv <= 1'b0;
			repeat (hold) @(posedge i_clk);
			drv <= 1'b1;
			repeat (hold) @(posedge i_clk);
		end
	endtask
endmodule

// ---- verification/timer2_updown_clockout_bench.sv ----
// Self-checking bench for the timer 2 block
`timescale 1ns/1ps
module timer2_updown_clockout_bench;
	logic clk, arst_n, psel, penable, pwrite, err;
	logic pready, pslverr, pin, dir, pin_out, oe_n, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	int hi, lo;
	tmr2_top dut (.i_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_count_clock_pin(pin),
		.i_direction_pin(dir), .o_count_clock_pin(pin_out),
		.o_count_clock_pin_oe_n(oe_n), .o_irq(irq));
	tmr2_far_model far (.i_clk(clk), .i_pin_out(pin_out),
		.i_pin_oe_n(oe_n), .o_pin(pin), .o_dir(dir));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer; waits for pready rather than assuming zero wait
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk({24'h0, r[7:0]}, {24'h0, exp});
	endtask
	task automatic wait_irq;
		int n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
	endtask
	task automatic t_reset;
		rd(8'hC8, 8'h00);
		rd(8'hC9, 8'h00);
		apb(1'b0, 8'hD0, 8'h00);
		chk({31'h0, err}, 32'h1);
	endtask
	task automatic t_up;
		wr(8'hCB, 8'h12);
		wr(8'hCA, 8'h34);
		wr(8'hCD, 8'hFF);
		wr(8'hCC, 8'hFE);
		wr(8'hC9, 8'h01);
		wr(8'hC8, 8'h04);
		wait_irq();
		rd(8'hC8, 8'hC4);
		rd(8'hCD, 8'h12);
	endtask
	task automatic t_down;
		wr(8'hC8, 8'h00);
		wr(8'hC8, 8'hC0);
		rd(8'hC8, 8'h00);
		far.set_dir(1'b0);
		repeat (4) @(posedge clk);
		wr(8'hCD, 8'h12);
		wr(8'hCC, 8'h36);
		wr(8'hC8, 8'h04);
		wait_irq();
		rd(8'hCD, 8'hFF);
		rd(8'hC8, 8'hC4);
	endtask
	// Pin edges and ticks arrive while run is clear
	task automatic t_hold;
		wr(8'hC8, 8'h00);
		wr(8'hC9, 8'h00);
		wr(8'hCC, 8'h55);
		wr(8'hCD, 8'h66);
		wr(8'hC8, 8'h02);
		far.pulse(3, 4);
		repeat (30) @(posedge clk);
		rd(8'hCC, 8'h55);
		rd(8'hCD, 8'h66);
	endtask
	task automatic t_ext;
		wr(8'hCC, 8'h10);
		wr(8'hCD, 8'h00);
		wr(8'hC8, 8'h06);
		far.pulse(5, 4);
		far.pulse(2, 20);
		rd(8'hCC, 8'h17);
		wr(8'hC8, 8'h00);
	endtask
	// Set-up order kept; reload FFFC gives a 16-cycle period
	task automatic t_clkout;
		wr(8'hC9, 8'h02);
		wr(8'hC8, 8'h00);
		wr(8'hCB, 8'hFF);
		wr(8'hCA, 8'hFC);
		wr(8'hCD, 8'hFF);
		wr(8'hCC, 8'hFC);
		wr(8'hC8, 8'h04);
		chk({31'h0, oe_n}, 32'h0);
		@(negedge clk);
		while (pin_out !== 1'b0) @(negedge clk);
		while (pin_out !== 1'b1) @(negedge clk);
		for (hi = 0; pin_out === 1'b1; hi++) @(negedge clk);
		for (lo = 0; pin_out === 1'b0; lo++) @(negedge clk);
		chk(hi, 4 * (32'h10000 - 32'hFFFC) / 2);
		chk(lo, hi);
		rd(8'hC8, 8'h04);
		wr(8'hC9, 8'h00);
		@(negedge clk);
		chk({31'h0, oe_n}, 32'h1);
	endtask
	task automatic final_report;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Reset for 8 cycles, then the scenarios in turn
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_up();
		t_down();
		t_hold();
		t_ext();
		t_clkout();
		final_report();
	end
endmodule
